// >>> acp_pkg.sv
// Shared constants for the converter control and output port
`default_nettype none
package acp_pkg;

    // Clock and timing
    localparam int CLK_PERIOD_NS  = 10;
    localparam int CONV_TIME_NS   = 480;
    localparam int ACQ_TIME_NS    = 250;
    localparam int SCLK_HALF_NS   = 40;
    localparam int CONV_CYC       = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACQ_CYC        = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SCLK_HALF_CYC  = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Serial frame
    localparam int          FRAME_BITS = 32;
    localparam logic [5:0]  BITS_LAST  = 6'h1F;
    localparam logic [5:0]  BITS_FULL  = 6'h20;
    localparam logic [5:0]  BITS_HALF  = 6'h0F;

    // Register offsets (byte addresses)
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_STATUS   = 8'h04;
    localparam logic [7:0] OFF_INT_STAT = 8'h08;
    localparam logic [7:0] OFF_INT_MASK = 8'h0C;
    localparam logic [7:0] OFF_RESULT   = 8'h10;

    // Control register fields
    localparam int CTRL_SERIAL_PARALLEL_SELECT  = 0;
    localparam int CTRL_CLK_SRC  = 1;
    localparam int CTRL_INV_SCLK = 2;
    localparam int CTRL_INV_SYNC = 3;
    localparam int CTRL_PWR_DOWN = 4;
    localparam int CTRL_CH_ORDER = 5;
    localparam int CTRL_IMPULSE  = 6;
    localparam int CTRL_W        = 7;
    localparam logic [6:0] CTRL_RESET = 7'h00;

    // Interrupt status fields
    localparam int INT_DONE  = 0;
    localparam int INT_RDERR = 1;
    localparam int INT_CHAN  = 2;
    localparam int INT_W     = 3;
    localparam logic [2:0] INT_RESET = 3'h0;

    // Synchroniser lanes
    localparam int SYN_CNV  = 0;
    localparam int SYN_CS   = 1;
    localparam int SYN_RD   = 2;
    localparam int SYN_RST  = 3;
    localparam int SYN_SCLK = 4;
    localparam int SYN_W    = 5;
    localparam logic [4:0] SYN_RESET = 5'h0F;

    typedef enum logic [2:0] {
        ACP_IDLE,
        ACP_CONV_A,
        ACP_CONV_B,
        ACP_LATCH,
        ACP_ACQ
    } acp_state_t;

endpackage : acp_pkg
`default_nettype wire

// >>> acp_sync.sv
// Two-flop synchroniser bank for pins entering the clk domain
`timescale 1ns/1ps
`default_nettype none
module acp_sync #(
    parameter int         W          = 1,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_lane
            logic stage1_ff;
            logic stage2_ff;
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    stage1_ff <= RESET_VAL[i];
                    stage2_ff <= RESET_VAL[i];
                end
                else
                begin
                    stage1_ff <= async_in[i];
                    stage2_ff <= stage1_ff;
                end
            end
            assign sync_out[i] = stage2_ff;
        end
    endgenerate

endmodule : acp_sync
`default_nettype wire

// >>> acp_top.sv
// Converter control, parallel/serial result port and APB registers
// Summary of operation
// - Parallel mode drives shared pins as bits 8-11
// - Serial mode floats parallel bits 12 to 15
// - Shift clock pin driven internally, else host input
// - Invert input picks shift clock update edge
// - Internal clock serial mode drives frame marker
// - Marker high framing data, low pulse mid-frame
// - Inverted marker low framing, high pulse mid-frame
// - Unfinished slave read at conversion end flags error
// - Busy high from start until results latched
// - Done strobe pulses low per channel finished
// - Output bus enabled only with select and read low
// - Select low gates the external shift clock
// - High reset input aborts conversion
// - Power-down lets current conversion finish, blocks more
// - Convert-start falling edge holds and converts
// - Impulse mode restarts if start still low
// - 32-bit shifter, MSB first, channel order selectable
// - External clock updates on rising, inverted falling
`timescale 1ns/1ps
`default_nettype none
module acp_top (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        convert_start_n,
    input  wire logic        cs_n,
    input  wire logic        rd_n,
    input  wire logic        converter_reset,
    input  wire logic        shift_clock_in,
    input  wire logic [15:0] result_a,
    input  wire logic [15:0] result_b,
    output logic      [15:0] pin_out,
    output logic      [15:0] pin_oe,
    output logic             busy,
    output logic             eoc_n,
    output logic             irq
);

    // Pin synchronisers
    logic [acp_pkg::SYN_W-1:0] syn_in;
    logic [acp_pkg::SYN_W-1:0] syn_out;

    assign syn_in = {shift_clock_in, converter_reset, rd_n, cs_n, convert_start_n};

    acp_sync #(
        .W         (acp_pkg::SYN_W),
        .RESET_VAL (acp_pkg::SYN_RESET)
    ) u_sync (
        .clk      (clk),
        .rst_n    (rst_n),
        .async_in (syn_in),
        .sync_out (syn_out)
    );

    wire cnv_s  = syn_out[acp_pkg::SYN_CNV];
    wire cs_s   = syn_out[acp_pkg::SYN_CS];
    wire rd_s   = syn_out[acp_pkg::SYN_RD];
    wire crst_s = syn_out[acp_pkg::SYN_RST];
    wire sclk_s = syn_out[acp_pkg::SYN_SCLK];

    // State
    acp_pkg::acp_state_t state_ff;
    acp_pkg::acp_state_t nxt_state;
    logic [15:0]                 cnt_ff;
    logic [15:0]                 nxt_cnt;
    logic [acp_pkg::CTRL_W-1:0]  ctrl_ff;
    logic [acp_pkg::INT_W-1:0]   int_stat_ff;
    logic [acp_pkg::INT_W-1:0]   int_mask_ff;
    logic [15:0]                 data_a_ff;
    logic [15:0]                 data_b_ff;
    logic                        data_valid_ff;
    logic                        busy_ff;
    logic                        eoc_n_ff;
    logic                        cnv_prev_ff;
    logic                        rd_prev_ff;
    logic                        sclk_prev_ff;
    logic [31:0]                 shreg_ff;
    logic [5:0]                  bit_cnt_ff;
    logic                        mst_run_ff;
    logic                        sclk_ff;
    logic [15:0]                 div_cnt_ff;
    logic                        mid_pulse_ff;
    logic                        read_done_ff;
    logic                        rderr_ff;
    logic                        par_sel_ff;
    logic [15:0]                 pin_out_ff;
    logic [15:0]                 pin_oe_ff;

    // Control decode
    wire ser_mode   = ctrl_ff[acp_pkg::CTRL_SERIAL_PARALLEL_SELECT];
    wire ext_clk    = ctrl_ff[acp_pkg::CTRL_CLK_SRC];
    wire inv_sclk   = ctrl_ff[acp_pkg::CTRL_INV_SCLK];
    wire inv_sync   = ctrl_ff[acp_pkg::CTRL_INV_SYNC];
    wire pwr_down   = ctrl_ff[acp_pkg::CTRL_PWR_DOWN];
    wire ch_order   = ctrl_ff[acp_pkg::CTRL_CH_ORDER];
    wire impulse    = ctrl_ff[acp_pkg::CTRL_IMPULSE];

    wire cnv_fall   = cnv_prev_ff & ~cnv_s;
    wire bus_en     = ~cs_s & ~rd_s;
    wire rd_rise    = rd_s & ~rd_prev_ff & ~cs_s;
    wire cnt_conv   = (cnt_ff == 16'(acp_pkg::CONV_CYC - 1));
    wire cnt_acq    = (cnt_ff == 16'(acp_pkg::ACQ_CYC - 1));
    wire a_done     = (state_ff == acp_pkg::ACP_CONV_A) && cnt_conv;
    wire b_done     = (state_ff == acp_pkg::ACP_CONV_B) && cnt_conv;
    wire latch_evt  = (state_ff == acp_pkg::ACP_LATCH);
    wire start_ok   = ~pwr_down;

    // Conversion sequencer
    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff + 16'h0001;
        case (state_ff)
            acp_pkg::ACP_IDLE:
            begin
                nxt_cnt = 16'h0000;
                if (cnv_fall && start_ok)
                    nxt_state = acp_pkg::ACP_CONV_A;
            end
            acp_pkg::ACP_CONV_A:
            begin
                if (cnt_conv)
                begin
                    nxt_state = acp_pkg::ACP_CONV_B;
                    nxt_cnt   = 16'h0000;
                end
            end
            acp_pkg::ACP_CONV_B:
            begin
                if (cnt_conv)
                begin
                    nxt_state = acp_pkg::ACP_LATCH;
                    nxt_cnt   = 16'h0000;
                end
            end
            acp_pkg::ACP_LATCH:
            begin
                nxt_cnt   = 16'h0000;
                nxt_state = impulse ? acp_pkg::ACP_ACQ : acp_pkg::ACP_IDLE;
            end
            acp_pkg::ACP_ACQ:
            begin
                if (cnt_acq)
                begin
                    nxt_cnt = 16'h0000;
                    // Start still held low: convert at once
                    if (!cnv_s && start_ok)
                        nxt_state = acp_pkg::ACP_CONV_A;
                    else
                        nxt_state = acp_pkg::ACP_IDLE;
                end
            end
            default:
            begin
                nxt_state = acp_pkg::ACP_IDLE;
                nxt_cnt   = 16'h0000;
            end
        endcase
    end

    wire nxt_busy = (nxt_state == acp_pkg::ACP_CONV_A) ||
                    (nxt_state == acp_pkg::ACP_CONV_B) ||
                    (nxt_state == acp_pkg::ACP_LATCH);

    // Converter reset pin acts like a synchronous abort
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff <= acp_pkg::ACP_IDLE;
            cnt_ff   <= 16'h0000;
            busy_ff  <= 1'b0;
            eoc_n_ff <= 1'b1;
        end
        else if (crst_s)
        begin
            state_ff <= acp_pkg::ACP_IDLE;
            cnt_ff   <= 16'h0000;
            busy_ff  <= 1'b0;
            eoc_n_ff <= 1'b1;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            busy_ff  <= nxt_busy;
            eoc_n_ff <= ~(a_done | b_done);
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnv_prev_ff  <= 1'b1;
            rd_prev_ff   <= 1'b1;
            sclk_prev_ff <= 1'b0;
        end
        else
        begin
            cnv_prev_ff  <= cnv_s;
            rd_prev_ff   <= rd_s;
            sclk_prev_ff <= sclk_s;
        end
    end

    // Per-channel results
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            data_a_ff     <= 16'h0000;
            data_b_ff     <= 16'h0000;
            data_valid_ff <= 1'b0;
        end
        else
        begin
            if (a_done)
                data_a_ff <= result_a;
            if (b_done)
                data_b_ff <= result_b;
            if (crst_s)
                data_valid_ff <= 1'b0;
            else if (latch_evt)
                data_valid_ff <= 1'b1;
        end
    end

    wire [15:0] first_word  = ch_order ? data_b_ff : data_a_ff;
    wire [15:0] second_word = ch_order ? data_a_ff : data_b_ff;

    // Serial engine: edge selection
    wire div_end   = (div_cnt_ff == 16'(acp_pkg::SCLK_HALF_CYC - 1));
    wire mst_tog   = mst_run_ff & div_end;
    // Idle level is ~inv_sclk so the first edge is a sampling edge
    wire mst_upd   = mst_tog & (sclk_ff == inv_sclk);
    wire ext_rise  = sclk_s & ~sclk_prev_ff;
    wire ext_fall  = ~sclk_s & sclk_prev_ff;
    wire ext_edge  = inv_sclk ? ext_fall : ext_rise;
    wire ext_upd   = ext_clk & ~cs_s & bus_en & ext_edge &
                     (bit_cnt_ff != acp_pkg::BITS_FULL);
    wire upd       = ser_mode & (ext_clk ? ext_upd : mst_upd);
    wire mst_last  = mst_upd & (bit_cnt_ff == acp_pkg::BITS_LAST);
    wire mst_start = ser_mode & ~ext_clk & bus_en & ~mst_run_ff & ~read_done_ff &
                     ~busy_ff & data_valid_ff;
    wire slv_part  = ext_clk & (bit_cnt_ff != 6'h00) &
                     (bit_cnt_ff != acp_pkg::BITS_FULL);
    wire rderr_evt = ser_mode & slv_part & latch_evt;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            shreg_ff     <= 32'h0000_0000;
            bit_cnt_ff   <= 6'h00;
            mst_run_ff   <= 1'b0;
            sclk_ff      <= 1'b1;
            div_cnt_ff   <= 16'h0000;
            mid_pulse_ff <= 1'b0;
            read_done_ff <= 1'b0;
            rderr_ff     <= 1'b0;
        end
        else if (crst_s)
        begin
            shreg_ff     <= 32'h0000_0000;
            bit_cnt_ff   <= 6'h00;
            mst_run_ff   <= 1'b0;
            sclk_ff      <= ~inv_sclk;
            div_cnt_ff   <= 16'h0000;
            mid_pulse_ff <= 1'b0;
            read_done_ff <= 1'b0;
            rderr_ff     <= 1'b0;
        end
        else if (latch_evt)
        begin
            // Fresh results replace anything half read
            shreg_ff     <= {first_word, second_word};
            bit_cnt_ff   <= 6'h00;
            mst_run_ff   <= 1'b0;
            sclk_ff      <= ~inv_sclk;
            div_cnt_ff   <= 16'h0000;
            mid_pulse_ff <= 1'b0;
            read_done_ff <= 1'b0;
            rderr_ff     <= rderr_evt;
        end
        else
        begin
            rderr_ff <= 1'b0;
            if (upd)
            begin
                shreg_ff     <= {shreg_ff[30:0], 1'b0};
                bit_cnt_ff   <= bit_cnt_ff + 6'h01;
                mid_pulse_ff <= (bit_cnt_ff == acp_pkg::BITS_HALF);
            end
            if (mst_start)
            begin
                mst_run_ff <= 1'b1;
                div_cnt_ff <= 16'h0000;
                sclk_ff    <= ~inv_sclk;
            end
            else if (!bus_en || mst_last)
            begin
                mst_run_ff <= 1'b0;
                div_cnt_ff <= 16'h0000;
                sclk_ff    <= ~inv_sclk;
            end
            else if (mst_run_ff)
            begin
                div_cnt_ff <= div_end ? 16'h0000 : div_cnt_ff + 16'h0001;
                if (mst_tog)
                    sclk_ff <= ~sclk_ff;
            end
            else
            begin
                sclk_ff <= ~inv_sclk;
            end
            if (!bus_en)
                read_done_ff <= 1'b0;
            else if (mst_last)
                read_done_ff <= 1'b1;
        end
    end

    // Frame marker: active level framing data, inverted for one bit mid-frame
    wire frame_on  = mst_run_ff & ~mid_pulse_ff;
    wire sync_lvl  = inv_sync ? ~frame_on : frame_on;

    // Parallel read alternates channels on each read strobe
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            par_sel_ff <= 1'b0;
        else if (latch_evt || crst_s)
            par_sel_ff <= 1'b0;
        else if (rd_rise && !ser_mode)
            par_sel_ff <= ~par_sel_ff;
    end

    wire [15:0] par_word = par_sel_ff ? second_word : first_word;
    wire [15:0] ser_word = {4'h0, rderr_ff, sync_lvl, sclk_ff, shreg_ff[31], 8'h00};
    wire [15:0] par_oe   = {16{bus_en}};
    wire [15:0] ser_oe   = {4'h0, bus_en & ext_clk, bus_en & ~ext_clk,
                            bus_en & ~ext_clk, bus_en, 8'h00};
    wire [15:0] nxt_pin_out = ser_mode ? ser_word : par_word;
    wire [15:0] nxt_pin_oe  = ser_mode ? ser_oe : par_oe;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_out_ff <= 16'h0000;
            pin_oe_ff  <= 16'h0000;
        end
        else
        begin
            pin_out_ff <= nxt_pin_out;
            pin_oe_ff  <= nxt_pin_oe;
        end
    end

    // APB slave, zero wait states
    wire apb_acc   = psel & penable;
    wire apb_wr    = apb_acc & pwrite;
    wire hit_ctrl  = (paddr == acp_pkg::OFF_CTRL);
    wire hit_stat  = (paddr == acp_pkg::OFF_STATUS);
    wire hit_int   = (paddr == acp_pkg::OFF_INT_STAT);
    wire hit_mask  = (paddr == acp_pkg::OFF_INT_MASK);
    wire hit_res   = (paddr == acp_pkg::OFF_RESULT);
    wire hit_any   = hit_ctrl | hit_stat | hit_int | hit_mask | hit_res;

    wire [acp_pkg::INT_W-1:0] int_set = {a_done | b_done, rderr_evt, latch_evt};
    wire [acp_pkg::INT_W-1:0] int_clr = (apb_wr && hit_int) ?
                                        pwdata[acp_pkg::INT_W-1:0] : 3'h0;
    // Set wins over a simultaneous write-one clear
    wire [acp_pkg::INT_W-1:0] nxt_int_stat = (int_stat_ff & ~int_clr) | int_set;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_ff     <= acp_pkg::CTRL_RESET;
            int_mask_ff <= acp_pkg::INT_RESET;
            int_stat_ff <= acp_pkg::INT_RESET;
        end
        else
        begin
            if (apb_wr && hit_ctrl)
                ctrl_ff <= pwdata[acp_pkg::CTRL_W-1:0];
            if (apb_wr && hit_mask)
                int_mask_ff <= pwdata[acp_pkg::INT_W-1:0];
            int_stat_ff <= nxt_int_stat;
        end
    end

    wire [31:0] stat_word = {23'h000000, bit_cnt_ff, mst_run_ff, data_valid_ff, busy_ff};

    assign prdata  = hit_ctrl ? {25'h0000000, ctrl_ff} :
                     hit_stat ? stat_word :
                     hit_int  ? {29'h00000000, int_stat_ff} :
                     hit_mask ? {29'h00000000, int_mask_ff} :
                     hit_res  ? {data_a_ff, data_b_ff} : 32'h0000_0000;
    assign pready  = 1'b1;
    assign pslverr = apb_acc & ~hit_any;

    assign pin_out = pin_out_ff;
    assign pin_oe  = pin_oe_ff;
    assign busy    = busy_ff;
    assign eoc_n   = eoc_n_ff;
    assign irq     = |(int_stat_ff & int_mask_ff);

endmodule : acp_top
`default_nettype wire

// >>> acp_checker_assertions.sv
// Pin-level checks of the converter port
`timescale 1ns/1ps
`default_nettype none
module acp_checker (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        cs_n,
    input wire logic        convert_start_n,
    input wire logic        converter_reset,
    input wire logic [15:0] pin_oe,
    input wire logic        busy,
    input wire logic        eoc_n
);
    logic [7:0] bcnt_ff;
    logic [7:0] nxt_bcnt;

    // Busy cycles, to place each channel's done pulse
    assign nxt_bcnt = busy ? bcnt_ff + 8'h01 : 8'h00;
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
            bcnt_ff <= 8'h00;
        else
            bcnt_ff <= nxt_bcnt;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    oe_gate_a: assert property (
        cs_n && $past(cs_n) && $past(cs_n, 2) && $past(cs_n, 3) |-> pin_oe == 16'h0000)
        else $error("Pins driven without select");
    par_float_a: assert property (
        |pin_oe[15:12] |-> pin_oe == 16'hFFFF) else $error("Upper pins driven in serial mode");
    busy_hold_a: assert property (
        $rose(busy) |-> busy [*8]) else $error("Busy dropped early");
    eoc_time_a: assert property (
        !eoc_n |-> busy && bcnt_ff >= 8'h28 && bcnt_ff <= 8'h68)
        else $error("Done pulse out of place");
    eoc_pulse_a: assert property (
        !eoc_n |=> eoc_n) else $error("Done pulse too long");
    abort_idle_a: assert property (
        converter_reset [*6] |-> !busy && eoc_n) else $error("Abort left conversion running");
    reset_idle_a: assert property (
        $rose(rst_n) |-> !busy && eoc_n && pin_oe == 16'h0000) else $error("Not idle after reset");
    start_edge_a: assert property (
        $rose(busy) |-> !$past(convert_start_n, 2)) else $error("Busy without start");
endmodule : acp_checker

bind acp_top acp_checker u_chk (
    .clk             (clk),
    .rst_n           (rst_n),
    .cs_n            (cs_n),
    .convert_start_n (convert_start_n),
    .converter_reset (converter_reset),
    .pin_oe          (pin_oe),
    .busy            (busy),
    .eoc_n           (eoc_n)
);
`default_nettype wire

// >>> acp_host_model.sv
// Host model: select and read strobes, external shift clock, serial capture
`timescale 1ns/1ps
`default_nettype none
module acp_host_model (
    input  wire logic        clk,
    input  wire logic [15:0] pin_out,
    input  wire logic [15:0] pin_oe,
    output logic             cs_n,
    output logic             rd_n,
    output logic             host_sclk
);
    logic sdo;
    logic last_ff = 1'b0;

    // Released data line shows the inverse of its last value
    assign sdo = pin_oe[8] ? pin_out[8] : ~last_ff;
    always @(posedge clk)
        last_ff <= sdo;
    initial
    begin
        cs_n = 1'b1;
        rd_n = 1'b1;
        host_sclk = 1'b0;
    end

    task automatic select(input logic on);
        cs_n <= ~on;
        rd_n <= ~on;
        repeat (6) @(posedge clk);
    endtask : select

    // Clock stands at its idle level outside frames
    task automatic read_ext(input int n, input logic inv, output logic [31:0] w);
        host_sclk <= inv;
        select(1'b1);
        for (int i = 0; i < n; i++)
        begin
            w = {w[30:0], sdo};
            host_sclk <= ~inv;
            repeat (8) @(posedge clk);
            host_sclk <= inv;
            repeat (8) @(posedge clk);
        end
    endtask : read_ext

    // Samples on the first edge away from the idle level
    task automatic read_int(input logic inv, input logic invm, output logic [31:0] w,
                            output int marks);
        marks = 0;
        select(1'b1);
        for (int i = 0; i < 32; i++)
        begin
            for (int k = 0; k < 20 && pin_out[9] === inv; k++)
                @(posedge clk);
            for (int k = 0; k < 20 && pin_out[9] !== inv; k++)
                @(posedge clk);
            w = {w[30:0], sdo};
            marks += int'(pin_out[10] === invm && pin_oe[10] === 1'b1);
        end
    endtask : read_int
endmodule : acp_host_model
`default_nettype wire

// >>> testbench.sv
// Self-checking bench for the converter control and output port
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        cnv_n = 1'b1;
    logic        crst = 1'b0;
    logic [15:0] ra = 16'h0;
    logic [15:0] rb = 16'h0;
    logic [15:0] pin_out;
    logic [15:0] pin_oe;
    logic        busy;
    logic        eoc_n;
    logic        irq;
    logic        cs_n;
    logic        rd_n;
    logic        hsclk;
    wire logic   sclk_w;
    logic [31:0] rd;
    logic [31:0] w;
    logic        err;
    int          num_errors = 0;
    int          checks_done = 0;
    int          eocs = 0;
    int          flags = 0;
    int          starts = 0;
    int          n;
    int          marks;

    assign sclk_w = pin_oe[9] ? pin_out[9] : hsclk;
    always #5 clk = ~clk;
    always @(posedge clk)
        eocs <= eocs + int'(eoc_n === 1'b0);
    always @(posedge clk)
        flags <= flags + int'(pin_oe[11] === 1'b1 && pin_out[11] === 1'b1);
    always @(posedge clk)
        starts <= starts + int'($rose(busy));

    acp_top uut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .convert_start_n(cnv_n), .cs_n(cs_n), .rd_n(rd_n), .converter_reset(crst),
        .shift_clock_in(sclk_w), .result_a(ra), .result_b(rb), .pin_out(pin_out),
        .pin_oe(pin_oe), .busy(busy), .eoc_n(eoc_n), .irq(irq));
    acp_host_model host (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .cs_n(cs_n),
        .rd_n(rd_n), .host_sclk(hsclk));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH %0t got %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    function automatic logic [31:0] ctl(input logic s, e, i, m, p, o, x);
        ctl = 32'h0;
        ctl[acp_pkg::CTRL_SERIAL_PARALLEL_SELECT] = s;
        ctl[acp_pkg::CTRL_CLK_SRC] = e;
        ctl[acp_pkg::CTRL_INV_SCLK] = i;
        ctl[acp_pkg::CTRL_INV_SYNC] = m;
        ctl[acp_pkg::CTRL_PWR_DOWN] = p;
        ctl[acp_pkg::CTRL_CH_ORDER] = o;
        ctl[acp_pkg::CTRL_IMPULSE] = x;
    endfunction : ctl

    task automatic wait_idle();
        for (int k = 0; k < 300 && busy !== 1'b0; k++)
            @(posedge clk);
        repeat (2) @(posedge clk);
    endtask : wait_idle

    task automatic convert();
        ra <= 16'($urandom);
        rb <= 16'($urandom);
        cnv_n <= 1'b0;
        repeat (8) @(posedge clk);
        cnv_n <= 1'b1;
        wait_idle();
    endtask : convert

    task automatic final_report();
        $display("Checks %0d, mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : final_report

    initial
    begin
        repeat (60000) @(posedge clk);
        num_errors++;
        final_report();
    end

    initial
    begin
        void'($urandom(5639));
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b0, 8'(4 * i), 32'h0);
            check(rd, 32'h0);
        end
        apb(1'b0, 8'h14, 32'h0);
        check({31'h0, err}, 32'h1);
        $display("Registers done");
        apb(1'b1, acp_pkg::OFF_INT_MASK, 32'h7);
        n = eocs;
        convert();
        check(32'(eocs - n), 32'h2);
        check({31'h0, irq}, 32'h1);
        apb(1'b0, acp_pkg::OFF_RESULT, 32'h0);
        check(rd, {ra, rb});
        host.select(1'b1);
        check({pin_oe, pin_out}, {16'hFFFF, ra});
        host.select(1'b0);
        apb(1'b1, acp_pkg::OFF_INT_STAT, 32'h7);
        check({31'h0, irq}, 32'h0);
        $display("Parallel done");
        for (int v = 0; v < 4; v++)
        begin
            apb(1'b1, acp_pkg::OFF_CTRL, ctl(1, 1, v[0], 0, 0, v[1], 0));
            convert();
            for (int k = 0; k < 24; k++) @(posedge clk) host.host_sclk <= k[3];
            host.read_ext(32, v[0], w);
            host.select(1'b0);
            check(w, v[1] ? {rb, ra} : {ra, rb});
            apb(1'b1, acp_pkg::OFF_CTRL, ctl(1, 0, v[0], v[1], 0, 0, 0));
            convert();
            host.read_int(v[0], v[1], w, marks);
            host.select(1'b0);
            check(w, {ra, rb});
            check(32'(marks), 32'h1);
        end
        $display("Serial done");
        apb(1'b1, acp_pkg::OFF_CTRL, ctl(1, 1, 0, 0, 0, 0, 0));
        convert();
        n = flags;
        host.read_ext(8, 1'b0, w);
        convert();
        check(32'(flags - n), 32'h1);
        apb(1'b0, acp_pkg::OFF_INT_STAT, 32'h0);
        check(32'(rd[acp_pkg::INT_RDERR]), 32'h1);
        host.select(1'b0);
        apb(1'b1, acp_pkg::OFF_INT_STAT, 32'h7);
        cnv_n <= 1'b0;
        repeat (8) @(posedge clk);
        apb(1'b1, acp_pkg::OFF_CTRL, ctl(0, 0, 0, 0, 1, 0, 0));
        cnv_n <= 1'b1;
        wait_idle();
        apb(1'b0, acp_pkg::OFF_INT_STAT, 32'h0);
        check(32'(rd[acp_pkg::INT_DONE]), 32'h1);
        n = starts;
        convert();
        check(32'(starts - n), 32'h0);
        $display("Power-down done");
        apb(1'b1, acp_pkg::OFF_CTRL, 32'h0);
        apb(1'b1, acp_pkg::OFF_INT_STAT, 32'h7);
        cnv_n <= 1'b0;
        repeat (20) @(posedge clk);
        crst <= 1'b1;
        repeat (8) @(posedge clk);
        crst <= 1'b0;
        cnv_n <= 1'b1;
        repeat (4) @(posedge clk);
        check({31'h0, busy}, 32'h0);
        apb(1'b0, acp_pkg::OFF_INT_STAT, 32'h0);
        check(32'(rd[acp_pkg::INT_DONE]), 32'h0);
        apb(1'b1, acp_pkg::OFF_CTRL, ctl(0, 0, 0, 0, 0, 0, 1));
        n = starts;
        cnv_n <= 1'b0;
        repeat (300) @(posedge clk);
        cnv_n <= 1'b1;
        wait_idle();
        check(32'(starts - n > 1), 32'h1);
        $display("Abort and pacing done");
        final_report();
    end
endmodule : testbench
`default_nettype wire
